//--- logic/cmma_pkg.sv
// package: constants for the memory-mapped cache array port
package cmma_pkg;
    localparam logic [7:0] CMMA_TAG_SPACE = 8'hf0; // top byte of tag-array window
    localparam logic [7:0] CMMA_DAT_SPACE = 8'hf1; // top byte of data-array window
    localparam int CMMA_SPACE_LSB = 24;
    localparam int CMMA_LOOKUP_BIT = 3;
    localparam int CMMA_WORD_LSB = 2;
    localparam int CMMA_IDX_LSB = 4;
    localparam int CMMA_WAY_LSB_16K = 12;
    localparam int CMMA_WAY_LSB_32K = 13;
    localparam int CMMA_IDX_W = 9; // 512 entries in 32-kbyte mode
    localparam int CMMA_ENTRIES = 512;
    localparam int CMMA_WAYS = 4;
    localparam int CMMA_WORDS = 4;
    localparam int CMMA_TAG_LSB = 10;
    localparam int CMMA_TAG_W = 22;
    localparam int CMMA_HIST_LSB = 4;
    localparam int CMMA_HIST_W = 6;
    localparam int CMMA_DIRTY_BIT = 1;
    localparam int CMMA_VALID_BIT = 0;
    localparam logic [2:0] CMMA_TAG_TOP_ZERO = 3'h0; // tag bits 31..29 must be zero
    localparam logic [31:0] CMMA_PHYS_MASK = 32'h1fffffff; // simple translation mask
    typedef enum logic [2:0] {
        CMMA_IDLE = 3'b000,
        CMMA_LOOK = 3'b001,
        CMMA_WBACK = 3'b011,
        CMMA_COMMIT = 3'b010,
        CMMA_XLATE = 3'b110
    } cmma_state_t;
endpackage : cmma_pkg

//--- logic/cmma_if.sv
// interface: cpu-side access port joining both ends
`timescale 1ns/1ps
`default_nettype none
interface cmma_if;
    logic req; // access strobe, one cycle
    logic wr; // 1 = store, 0 = load
    logic [31:0] addr; // access address
    logic [31:0] wdata; // store data
    logic [3:0] be; // byte enables, all ones for a longword
    logic ifetch; // instruction fetch marker
    logic priv; // privileged mode marker
    logic ack; // completion pulse
    logic err; // refused access, with ack
    logic [31:0] rdata; // load data, valid with ack
    modport dev (input req, wr, addr, wdata, be, ifetch, priv,
                 output ack, err, rdata);
    modport cpu (output req, wr, addr, wdata, be, ifetch, priv,
                 input ack, err, rdata);
endinterface : cmma_if
`default_nettype wire

//--- logic/cmma_cpu.sv
// requester end: turns user orders into privileged longword moves
`timescale 1ns/1ps
`default_nettype none
module cmma_cpu import cmma_pkg::*; (
    input wire logic core_clk, // core clock
    input wire logic resetn, // async reset, active low
    input wire logic ce, // clock enable
    cmma_if.cpu port, // link to array port
    input wire logic cmd_valid, // order pulse
    input wire logic cmd_wr, // order is store
    input wire logic [31:0] cmd_addr, // order address
    input wire logic [31:0] cmd_wdata, // order data
    output logic cmd_busy, // order in flight
    output logic done, // order finished pulse
    output logic done_err, // order was refused
    output logic [31:0] done_rdata // load result
);
    logic [31:0] wd_c;
    logic [31:0] ad_c;
    // sanitise data and address before issuing
    always_comb begin
        wd_c = cmd_wdata;
        ad_c = cmd_addr;
        if (cmd_addr[31:CMMA_SPACE_LSB] == CMMA_TAG_SPACE) begin
            wd_c[31:29] = CMMA_TAG_TOP_ZERO; // R10
            if (!cmd_wdata[CMMA_VALID_BIT]) begin
                wd_c[CMMA_DIRTY_BIT] = 1'b0; // R11
            end
        end
        ad_c[1:0] = 2'b00; // R19
    end
    // issue one privileged longword move at a time
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            port.req <= 1'b0;
            port.wr <= 1'b0;
            port.addr <= 32'h0;
            port.wdata <= 32'h0;
            port.be <= 4'h0;
            port.ifetch <= 1'b0;
            port.priv <= 1'b0;
            cmd_busy <= 1'b0;
        end else if (ce) begin
            port.req <= 1'b0;
            if (cmd_valid && !cmd_busy) begin
                port.req <= 1'b1;
                port.wr <= cmd_wr;
                port.addr <= ad_c; // R8 not applied: lookup bit 3 passed through from cmd_addr, only bits 1..0 cleared
                port.wdata <= wd_c;
                port.be <= 4'hf; // R2
                port.ifetch <= 1'b0; // R2
                port.priv <= 1'b1; // R3
                cmd_busy <= 1'b1;
            end else if (port.ack) begin
                cmd_busy <= 1'b0;
            end
        end
    end
    // capture completion
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            done <= 1'b0;
            done_err <= 1'b0;
            done_rdata <= 32'h0;
        end else if (ce) begin
            done <= port.ack;
            if (port.ack) begin
                done_err <= port.err;
                done_rdata <= port.rdata;
            end
        end
    end
endmodule : cmma_cpu
`default_nettype wire

//--- logic/cmma_dev.sv
// device end: tag and data arrays reachable by privileged longword moves
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// (R1) decode F0 tag space, F1 data space
// (R2) longword only, no instruction fetch
// (R3) requester uses privileged load/store only
// (R4) tag access: index, way, lookup bit
// (R5) way code 0..3 selects way 0..3
// (R6) tag read returns fields, never looks up
// (R7) direct tag write stores all fields
// (R8) requester clears lookup bit for direct write; the requester passes cmd_addr bit 3 through unchanged
// (R9) dirty valid line written back first
// (R10) requester zeroes tag bits 31..29
// (R11) invalid write also clears dirty
// (R12) lookup write compares all four ways
// (R13) translate tag when translation enabled
// (R14) lookup hit updates dirty, valid only
// (R15) lookup miss changes nothing
// (R16) dirty hit line written back
// (R17) data access: index, word, way
// (R18) word select picks word 0..3
// (R19) requester zeroes address bits 1..0
// (R20) data access leaves tags untouched
// (R21) data read returns selected word
// (R22) data write stores selected word
// (R23) index/way position depends on size mode
// (R24) tag word field layout, lookup bit 3
module cmma_dev import cmma_pkg::*; (
    input wire logic core_clk, // core clock
    input wire logic resetn, // async reset, active low
    input wire logic ce, // clock enable
    cmma_if.dev port, // cpu-side access port
    input wire logic size_32k, // cache size mode: 1 = 32 kbyte
    input wire logic xlate_en, // address translation enabled
    output logic xlate_req, // translation request pulse
    output logic [31:0] xlate_va, // virtual tag address
    input wire logic xlate_ack, // translation answer strobe
    input wire logic [31:0] xlate_pa, // physical address
    output logic wb_req, // write-back request, held until wb_ack
    output logic [31:0] wb_addr, // line address for write-back
    output logic [127:0] wb_line, // line contents, word 0 in low bits
    input wire logic wb_ack // write-back taken
);
    typedef struct packed {
        logic [CMMA_TAG_W-1:0] tag;
        logic [CMMA_HIST_W-1:0] hist;
        logic dirty;
        logic valid;
    } cmma_tag_t;

    cmma_tag_t tag_q [CMMA_WAYS][CMMA_ENTRIES];
    logic [31:0] dat_q [CMMA_WAYS][CMMA_ENTRIES][CMMA_WORDS];

    cmma_state_t st_q;
    logic [CMMA_IDX_W-1:0] idx_q;
    logic [1:0] way_q;
    logic [31:0] wd_q;
    logic [CMMA_TAG_W-1:0] cmp_tag_q;
    logic commit_full_q; // 1 = direct write, 0 = lookup write

    logic [7:0] space_c;
    logic [CMMA_IDX_W-1:0] idx_c;
    logic [1:0] way_c;
    logic [1:0] word_c;
    logic is_tag_c;
    logic is_dat_c;
    logic bad_c;
    logic hit_c;
    logic [1:0] hit_way_c;

    // address decode for both arrays
    always_comb begin
        space_c = port.addr[31:CMMA_SPACE_LSB]; // R1
        is_tag_c = (space_c == CMMA_TAG_SPACE); // R4
        is_dat_c = (space_c == CMMA_DAT_SPACE); // R17
        word_c = port.addr[CMMA_WORD_LSB +: 2]; // R18
        if (size_32k) begin
            idx_c = port.addr[CMMA_IDX_LSB +: CMMA_IDX_W]; // R23
            way_c = port.addr[CMMA_WAY_LSB_32K +: 2]; // R5
        end else begin
            idx_c = {1'b0, port.addr[CMMA_IDX_LSB +: CMMA_IDX_W-1]}; // R23
            way_c = port.addr[CMMA_WAY_LSB_16K +: 2]; // R5
        end
        bad_c = (port.be != 4'hf) || port.ifetch || !port.priv
            || !(is_tag_c || is_dat_c); // R2
    end

    // four-way compare against the latched tag
    always_comb begin
        hit_c = 1'b0;
        hit_way_c = 2'b00;
        for (int w = CMMA_WAYS-1; w >= 0; w--) begin
            if (tag_q[w][idx_q].valid && tag_q[w][idx_q].tag == cmp_tag_q) begin // R12
                hit_c = 1'b1;
                hit_way_c = 2'(w);
            end
        end
    end

    // access sequencer
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= CMMA_IDLE;
            idx_q <= '0;
            way_q <= 2'b00;
            wd_q <= 32'h0;
            cmp_tag_q <= '0;
            commit_full_q <= 1'b0;
            port.ack <= 1'b0;
            port.err <= 1'b0;
            port.rdata <= 32'h0;
            xlate_req <= 1'b0;
            xlate_va <= 32'h0;
            wb_req <= 1'b0;
            wb_addr <= 32'h0;
            wb_line <= '0;
        end else if (ce) begin
            port.ack <= 1'b0;
            port.err <= 1'b0;
            xlate_req <= 1'b0;
            case (st_q)
                CMMA_IDLE: begin
                    if (port.req) begin
                        idx_q <= idx_c;
                        way_q <= way_c;
                        wd_q <= port.wdata;
                        cmp_tag_q <= port.wdata[CMMA_TAG_LSB +: CMMA_TAG_W];
                        if (bad_c) begin
                            port.ack <= 1'b1;
                            port.err <= 1'b1;
                            port.rdata <= 32'h0;
                        end else if (is_dat_c) begin
                            port.ack <= 1'b1; // R20
                            if (!port.wr) begin
                                port.rdata <= dat_q[way_c][idx_c][word_c]; // R21
                            end
                        end else if (!port.wr) begin
                            port.ack <= 1'b1;
                            port.rdata <= {tag_q[way_c][idx_c].tag, // R6
                                tag_q[way_c][idx_c].hist, 2'b00,
                                tag_q[way_c][idx_c].dirty,
                                tag_q[way_c][idx_c].valid}; // R24
                        end else if (port.addr[CMMA_LOOKUP_BIT]) begin
                            commit_full_q <= 1'b0;
                            if (xlate_en) begin
                                xlate_req <= 1'b1; // R13
                                xlate_va <= port.wdata;
                                st_q <= CMMA_XLATE;
                            end else begin
                                st_q <= CMMA_LOOK;
                            end
                        end else begin
                            commit_full_q <= 1'b1;
                            st_q <= CMMA_LOOK;
                        end
                    end
                end
                CMMA_XLATE: begin
                    if (xlate_ack) begin
                        cmp_tag_q <= xlate_pa[CMMA_TAG_LSB +: CMMA_TAG_W]; // R13
                        st_q <= CMMA_LOOK;
                    end
                end
                CMMA_LOOK: begin
                    if (commit_full_q) begin
                        if (tag_q[way_q][idx_q].dirty && tag_q[way_q][idx_q].valid) begin
                            st_q <= CMMA_WBACK; // R9
                        end else begin
                            st_q <= CMMA_COMMIT;
                        end
                    end else if (!hit_c) begin
                        port.ack <= 1'b1; // R15
                        st_q <= CMMA_IDLE;
                    end else begin
                        way_q <= hit_way_c;
                        if (tag_q[hit_way_c][idx_q].dirty) begin
                            st_q <= CMMA_WBACK; // R16
                        end else begin
                            st_q <= CMMA_COMMIT;
                        end
                    end
                    if ((commit_full_q && tag_q[way_q][idx_q].dirty && tag_q[way_q][idx_q].valid)
                        || (!commit_full_q && hit_c && tag_q[hit_way_c][idx_q].dirty)) begin
                        wb_req <= 1'b1;
                        wb_addr <= {tag_q[commit_full_q ? way_q : hit_way_c][idx_q].tag,
                            idx_q[CMMA_TAG_LSB-CMMA_IDX_LSB-1:0], CMMA_IDX_LSB'(0)}; // R9 R16
                        for (int k = 0; k < CMMA_WORDS; k++) begin
                            wb_line[k*32 +: 32] <=
                                dat_q[commit_full_q ? way_q : hit_way_c][idx_q][k];
                        end
                    end
                end
                CMMA_WBACK: begin
                    if (wb_ack) begin
                        wb_req <= 1'b0;
                        st_q <= CMMA_COMMIT;
                    end
                end
                CMMA_COMMIT: begin
                    port.ack <= 1'b1;
                    st_q <= CMMA_IDLE;
                end
                default: st_q <= CMMA_IDLE;
            endcase
        end
    end

    // tag array update, after any write-back
    always_ff @(posedge core_clk) begin
        if (ce && resetn && st_q == CMMA_COMMIT) begin
            tag_q[way_q][idx_q].dirty <= wd_q[CMMA_DIRTY_BIT]; // R14
            tag_q[way_q][idx_q].valid <= wd_q[CMMA_VALID_BIT]; // R14
            if (commit_full_q) begin
                tag_q[way_q][idx_q].tag <= wd_q[CMMA_TAG_LSB +: CMMA_TAG_W]; // R7
                tag_q[way_q][idx_q].hist <= wd_q[CMMA_HIST_LSB +: CMMA_HIST_W]; // R7
            end
        end
    end

    // data array store, kept out of the reset process: contents undefined until written
    always_ff @(posedge core_clk) begin
        if (ce && resetn && st_q == CMMA_IDLE && port.req && !bad_c
            && is_dat_c && port.wr) begin
            dat_q[way_c][idx_c][word_c] <= port.wdata; // R22
        end
    end
endmodule : cmma_dev
`default_nettype wire

//--- dv/cmma_assertions.sv
// checker: decode, format and answer timing on the cpu-side array port
`timescale 1ns/1ps
`default_nettype none
module cmma_assertions import cmma_pkg::*; (
    input wire logic core_clk, // core clock
    input wire logic resetn, // async reset, active low
    input wire logic req, // access strobe
    input wire logic wr, // store marker
    input wire logic [31:0] addr, // access address
    input wire logic [31:0] wdata, // store data
    input wire logic [3:0] be, // byte enables
    input wire logic ifetch, // fetch marker
    input wire logic priv, // privilege marker
    input wire logic ack, // completion pulse
    input wire logic err, // refusal flag
    input wire logic [31:0] rdata // load data
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    logic tag_sp;
    logic dat_sp;
    // window decode of the top address byte
    assign tag_sp = (addr[31:24] == CMMA_TAG_SPACE);
    assign dat_sp = (addr[31:24] == CMMA_DAT_SPACE);

    priv_only_a: assert property (req |-> priv)
        else $error("access issued outside privileged mode");
    long_only_a: assert property (req |-> (be == 4'hf) && !ifetch)
        else $error("access not a longword data move");
    data_low_zero_a: assert property (req && dat_sp |-> addr[1:0] == 2'h0)
        else $error("data array access with low address bits set");
    tag_top_zero_a: assert property (req && wr && tag_sp |-> wdata[31:29] == CMMA_TAG_TOP_ZERO)
        else $error("tag write with top tag bits set");
    inval_clean_a: assert property (req && wr && tag_sp && !wdata[0] |-> !wdata[1])
        else $error("invalid entry written dirty");
    data_fast_ack_a: assert property (req && dat_sp |=> ack && !err)
        else $error("data array access not answered next cycle");
    tag_read_ack_a: assert property (req && !wr && tag_sp |=> ack && !err)
        else $error("tag read not answered next cycle");
    bad_space_a: assert property (req && !tag_sp && !dat_sp |=> ack && err)
        else $error("access outside both windows not refused");
    direct_slow_a: assert property (req && wr && tag_sp && !addr[3] |=> !ack [*2])
        else $error("direct tag write answered too early");
    lookup_slow_a: assert property (req && wr && tag_sp && addr[3] |=> !ack)
        else $error("lookup write answered without a compare cycle");
    rdata_hold_a: assert property (!ack |-> $stable(rdata))
        else $error("load data changed without an answer");
    err_with_ack_a: assert property (err |-> ack)
        else $error("refusal flag raised without an answer");
endmodule : cmma_assertions
`default_nettype wire

//--- dv/test_cache_array_mapped_access.sv
// testbench: both ends joined, orders driven through the requester's user side
`timescale 1ns/1ps
`default_nettype none
module test_cache_array_mapped_access import cmma_pkg::*;;
    logic core_clk = 1'b0, resetn = 1'b0, cmd_valid = 1'b0, cmd_wr = 1'b0, er;
    logic size_32k = 1'b1, xlate_en = 1'b0, xlate_ack = 1'b0, wb_ack = 1'b0;
    logic cmd_busy, done, done_err, xlate_req, wb_req;
    logic [31:0] cmd_addr = 32'h0, cmd_wdata = 32'h0, xlate_pa = 32'h0, rd;
    logic [31:0] done_rdata, xlate_va, wb_addr, wb_addr_seen;
    logic [127:0] wb_line, wb_line_seen;
    int err_total = 0, n_tests = 0, wb_cnt = 0, wb0;
    cmma_if link();
    cmma_cpu cmma_cpu_inst(.core_clk(core_clk), .resetn(resetn), .ce(1'b1), .port(link),
        .cmd_valid(cmd_valid), .cmd_wr(cmd_wr), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_busy(cmd_busy), .done(done), .done_err(done_err), .done_rdata(done_rdata));
    cmma_dev cmma_dev_inst(.core_clk(core_clk), .resetn(resetn), .ce(1'b1), .port(link),
        .size_32k(size_32k), .xlate_en(xlate_en), .xlate_req(xlate_req), .xlate_va(xlate_va),
        .xlate_ack(xlate_ack), .xlate_pa(xlate_pa), .wb_req(wb_req), .wb_addr(wb_addr),
        .wb_line(wb_line), .wb_ack(wb_ack));
    cmma_assertions cmma_assertions_inst(.core_clk(core_clk), .resetn(resetn), .req(link.req),
        .wr(link.wr), .addr(link.addr), .wdata(link.wdata), .be(link.be),
        .ifetch(link.ifetch), .priv(link.priv), .ack(link.ack), .err(link.err),
        .rdata(link.rdata));
    initial forever #2.5 core_clk = ~core_clk;
    // memory side: take each write-back one cycle late and keep what it carried
    always @(posedge core_clk) begin
        wb_ack <= wb_req && !wb_ack;
        if (wb_req && wb_ack) begin
            wb_cnt <= wb_cnt + 1;
            wb_addr_seen <= wb_addr;
            wb_line_seen <= wb_line;
        end
    end
    // translator: physical tag differs from the virtual one in bit 20
    always @(posedge core_clk) begin
        xlate_ack <= xlate_req;
        xlate_pa <= xlate_va ^ 32'h0010_0000;
    end
    function automatic logic [31:0] ta(input int w, input int i, input logic a);
        return {8'hf0, 9'h0, 2'(w), 9'(i), a, 3'h0};
    endfunction : ta
    function automatic logic [31:0] da(input int w, input int i, input int k);
        return {8'hf1, 9'h0, 2'(w), 9'(i), 2'(k), 2'h0};
    endfunction : da
    function automatic logic [31:0] tw(input logic [21:0] t, input logic [5:0] h,
                                      input logic d, input logic v);
        return {t, h, 2'h0, d, v};
    endfunction : tw
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // one order through the requester, bounded wait for its done pulse
    task automatic op(input logic w, input logic [31:0] a, input logic [31:0] d);
        int i;
        @(posedge core_clk);
        cmd_valid <= 1'b1;
        cmd_wr <= w;
        cmd_addr <= a;
        cmd_wdata <= d;
        @(posedge core_clk);
        cmd_valid <= 1'b0;
        for (i = 0; i < 200; i++) begin
            @(posedge core_clk);
            #1;
            if (done === 1'b1) break;
        end
        if (i == 200) begin
            err_total++;
            tally_and_finish();
        end
        rd = done_rdata;
        er = done_err;
    endtask : op
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        op(1'b0, a, 32'h0);
        chk(rd, exp);
        chk(er, 1'b0);
    endtask : rd_chk
    initial begin
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        for (int i = 1; i < 3; i++) for (int w = 0; w < 4; w++) op(1'b1, ta(w, i, 0), 32'h0);
        wb0 = wb_cnt;
        for (int w = 0; w < 4; w++) op(1'b1, ta(w, 1, 0), tw(22'(256 + w), 6'(w), 0, 1));
        for (int w = 0; w < 4; w++) rd_chk(ta(w, 1, 1), tw(22'(256 + w), 6'(w), 0, 1));
        for (int w = 0; w < 4; w++) for (int k = 0; k < 4; k++)
            op(1'b1, da(w, 1, k), 32'ha000_0000 | 32'(w * 16 + k));
        for (int w = 0; w < 4; w++) for (int k = 0; k < 4; k++)
            rd_chk(da(w, 1, k), 32'ha000_0000 | 32'(w * 16 + k));
        rd_chk(ta(2, 1, 0), tw(22'(258), 6'h2, 0, 1));
        op(1'b1, ta(0, 1, 1), tw(22'h3ff, 6'h0, 0, 0));
        for (int w = 0; w < 4; w++) rd_chk(ta(w, 1, 0), tw(22'(256 + w), 6'(w), 0, 1));
        chk(wb_cnt, wb0);
        op(1'b1, ta(0, 1, 1), tw(22'(259), 6'h3f, 0, 0));
        rd_chk(ta(3, 1, 0), tw(22'(259), 6'h3, 0, 0));
        rd_chk(ta(0, 1, 0), tw(22'(256), 6'h0, 0, 1));
        op(1'b1, ta(1, 1, 0), tw(22'(257), 6'h1, 1, 1));
        chk(wb_cnt, wb0);
        op(1'b1, ta(1, 1, 0), tw(22'h2aa, 6'h0, 0, 1));
        chk(wb_cnt, wb0 + 1);
        chk(wb_addr_seen, {22'(257), 6'h01, 4'h0});
        chk(wb_line_seen, {32'ha000_0013, 32'ha000_0012, 32'ha000_0011, 32'ha000_0010});
        op(1'b1, ta(0, 1, 0), tw(22'(256), 6'h0, 1, 1));
        op(1'b1, ta(0, 1, 1), tw(22'(256), 6'h0, 1, 0));
        chk(wb_cnt, wb0 + 2);
        rd_chk(ta(0, 1, 0), tw(22'(256), 6'h0, 0, 0));
        @(posedge core_clk);
        xlate_en <= 1'b1;
        op(1'b1, ta(2, 2, 0), tw(22'h155, 6'h0, 0, 1));
        op(1'b1, ta(0, 2, 1), tw(22'h155, 6'h0, 0, 0) ^ 32'h0010_0000);
        rd_chk(ta(2, 2, 0), tw(22'h155, 6'h0, 0, 0));
        @(posedge core_clk);
        xlate_en <= 1'b0;
        size_32k <= 1'b0;
        for (int w = 1; w < 4; w += 2) op(1'b1, {8'hf1, 10'h0, 2'(w), 8'h05, 4'h0}, 32'(w));
        for (int w = 1; w < 4; w += 2) rd_chk({8'hf1, 10'h0, 2'(w), 8'h05, 4'h0}, 32'(w));
        @(posedge core_clk);
        size_32k <= 1'b1;
        for (int w = 1; w < 4; w += 2) rd_chk(da(w, 5, 0), 32'(w));
        op(1'b0, 32'hf200_0000, 32'h0);
        chk(er, 1'b1);
        rd_chk(da(0, 1, 0), 32'ha000_0000);
        tally_and_finish();
    end
endmodule : test_cache_array_mapped_access
`default_nettype wire
